// *** upcc_crc_engine.sv ***
// Serial CRC-8 engine, one bit per clock, least significant bit first.
`timescale 1ns/1ns
`default_nettype none

module upcc_crc_engine (
    upcc_crc_if.eng bus
);
    logic [upcc_pkg::CRC_W-1:0] rem_reg;
    logic [upcc_pkg::CRC_W-1:0] rem_next;
    logic feedback;

    // The register shifts right so the bit entering is paired with bit zero.
    always_comb begin
        feedback = rem_reg[0] ^ bus.din;
        rem_next = rem_reg;
        if (bus.clr) begin
            rem_next = upcc_pkg::CLEAR_VALUE;
        end else if (bus.shift) begin
            rem_next = {1'b0, rem_reg[upcc_pkg::CRC_W-1:1]}
                ^ (feedback ? upcc_pkg::REFLECTED_GENERATOR_CONST
                            : upcc_pkg::CLEAR_VALUE);
        end
    end

    always_ff @(posedge bus.clk or posedge bus.rst) begin
        if (bus.rst) begin
            rem_reg <= upcc_pkg::CLEAR_VALUE;
        end else begin
            rem_reg <= rem_next;
        end
    end

    assign bus.rem = rem_reg;
endmodule : upcc_crc_engine

`default_nettype wire

// *** upcc_crc_if.sv ***
// Control and remainder signals between a user of the CRC engine and the engine.
`timescale 1ns/1ns
`default_nettype none

interface upcc_crc_if (
    input wire logic clk,
    input wire logic rst
);
    logic clr;
    logic shift;
    logic din;
    logic [upcc_pkg::CRC_W-1:0] rem;

    modport ctrl (
        output clr,
        output shift,
        output din,
        input rem
    );

    modport eng (
        input clk,
        input rst,
        input clr,
        input shift,
        input din,
        output rem
    );
endinterface : upcc_crc_if

`default_nettype wire

// *** upcc_err_flags.sv ***
// Sticky check error flags for the up path, down path and summary.
`timescale 1ns/1ns
`default_nettype none

module upcc_err_flags (
    input wire logic clk,
    input wire logic rst,
    input wire logic set_up,
    input wire logic set_down,
    input wire logic [upcc_pkg::CLR_W-1:0] clear,
    output logic [upcc_pkg::NUM_PATHS-1:0] second_alert_status_reg,
    output logic first_alert_status_reg
);
    logic [upcc_pkg::NUM_PATHS-1:0] path_next;
    logic summary_next;

    // A set in the same cycle as a clear wins, so no failure is lost.
    always_comb begin
        path_next = second_alert_status_reg;
        summary_next = first_alert_status_reg;
        if (clear[upcc_pkg::CLR_UP]) begin
            path_next[upcc_pkg::UP_PATH] = 1'b0;
        end
        if (clear[upcc_pkg::CLR_DOWN]) begin
            path_next[upcc_pkg::DOWN_PATH] = 1'b0;
        end
        if (clear[upcc_pkg::CLR_SUMMARY]) begin
            summary_next = 1'b0;
        end
        if (set_up) begin
            path_next[upcc_pkg::UP_PATH] = 1'b1;
        end
        if (set_down) begin
            path_next[upcc_pkg::DOWN_PATH] = 1'b1;
        end
        if (set_up || set_down) begin
            summary_next = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            second_alert_status_reg <= '0;
            first_alert_status_reg <= 1'b0;
        end else begin
            second_alert_status_reg <= path_next;
            first_alert_status_reg <= summary_next;
        end
    end
endmodule : upcc_err_flags

`default_nettype wire

// *** upcc_host_model.sv ***
// Host side receiver that checks outgoing packets with its own check byte engine.
`timescale 1ns/1ns
`default_nettype none

module upcc_host_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic out_valid,
    input wire logic out_is_check,
    input wire logic [7:0] out_byte,
    output logic out_ready,
    output logic done,
    output logic [7:0] rem,
    output logic [7:0] data_rem,
    output logic [7:0] check
);
    logic [2:0] cnt;

    function automatic logic [7:0] step(input logic [7:0] r, input logic [7:0] b);
        r = r ^ b;
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ 8'hB2) : (r >> 1);
        end
        return r;
    endfunction : step

    // A slow host takes a byte in only two cycles of every eight.
    assign out_ready = !slow || cnt[2:1] == 2'b11;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 3'h0;
            done <= 1'b0;
            rem <= 8'h00;
            data_rem <= 8'h00;
            check <= 8'h00;
        end else begin
            cnt <= cnt + 3'h1;
            if (out_valid && out_ready) begin
                rem <= step(done ? 8'h00 : rem, out_byte);
                if (out_is_check) begin
                    check <= out_byte;
                    done <= 1'b1;
                end else begin
                    data_rem <= step(done ? 8'h00 : data_rem, out_byte);
                    done <= 1'b0;
                end
            end
        end
    end
endmodule : upcc_host_model

`default_nettype wire

// *** upcc_packet_checker.sv ***
// Packet check byte verification on receive paths and generation on transmit.
`timescale 1ns/1ns
`default_nettype none

module upcc_packet_checker (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic DUAL_UART,
    input wire logic [upcc_pkg::NUM_PATHS-1:0] RX_VALID,
    input wire logic [upcc_pkg::NUM_PATHS-1:0] RX_FIRST,
    input wire logic [upcc_pkg::NUM_PATHS*upcc_pkg::CRC_W-1:0] RX_BYTE,
    input wire logic [upcc_pkg::NUM_PATHS*upcc_pkg::KIND_W-1:0] RX_KIND,
    output logic [upcc_pkg::NUM_PATHS-1:0] RX_READY,
    output logic [upcc_pkg::NUM_PATHS-1:0] CMD_ACCEPT,
    output logic [upcc_pkg::NUM_PATHS-1:0] CMD_REJECT,
    input wire logic [upcc_pkg::CLR_W-1:0] FLAG_CLEAR,
    output logic UP_PATH_CHECK_ERROR_FLAG,
    output logic DOWN_PATH_CHECK_ERROR_FLAG,
    output logic SUMMARY_CHECK_ERROR_FLAG,
    input wire logic TX_VALID,
    input wire logic TX_FIRST,
    input wire logic TX_LAST,
    input wire logic [upcc_pkg::CRC_W-1:0] TX_BYTE,
    output logic TX_READY,
    output logic OUT_VALID,
    output logic [upcc_pkg::CRC_W-1:0] OUT_BYTE,
    output logic OUT_IS_CHECK,
    input wire logic OUT_READY
);
    // ****************************************************************
    // Receive paths
    // ****************************************************************
    logic [upcc_pkg::NUM_PATHS-1:0] ready_reg;
    logic [upcc_pkg::NUM_PATHS-1:0] accept_reg;
    logic [upcc_pkg::NUM_PATHS-1:0] reject_reg;
    logic [upcc_pkg::NUM_PATHS-1:0] ready_next;
    logic [upcc_pkg::NUM_PATHS-1:0] accept_next;
    logic [upcc_pkg::NUM_PATHS-1:0] reject_next;

    genvar p;
    generate
        for (p = 0; p < upcc_pkg::NUM_PATHS; p++) begin : g_path
            upcc_pkg::upcc_rx_state_e state_reg;
            upcc_pkg::upcc_rx_state_e state_next;
            logic [upcc_pkg::CRC_W-1:0] shift_reg;
            logic [upcc_pkg::CRC_W-1:0] shift_next;
            logic [upcc_pkg::BIT_CNT_W-1:0] count_reg;
            logic [upcc_pkg::BIT_CNT_W-1:0] count_next;
            logic take;
            logic [upcc_pkg::CRC_W-1:0] rx_byte;
            upcc_pkg::upcc_kind_e rx_kind;

            upcc_crc_if crc_bus (
                .clk(SYS_CLK),
                .rst(RESET)
            );

            upcc_crc_engine u_engine (
                .bus(crc_bus.eng)
            );

            assign rx_byte = RX_BYTE[p*upcc_pkg::CRC_W +: upcc_pkg::CRC_W];
            assign rx_kind = upcc_pkg::upcc_kind_e'(
                RX_KIND[p*upcc_pkg::KIND_W +: upcc_pkg::KIND_W]);
            assign take = RX_VALID[p] & ready_reg[p];

            always_comb begin
                state_next = state_reg;
                shift_next = shift_reg;
                count_next = count_reg;
                ready_next[p] = ready_reg[p];
                accept_next[p] = 1'b0;
                reject_next[p] = 1'b0;
                crc_bus.clr = 1'b0;
                crc_bus.shift = 1'b0;
                crc_bus.din = shift_reg[0];
                case (state_reg)
                    upcc_pkg::UPCC_RX_IDLE: begin
                        if (take) begin
                            case (rx_kind)
                                upcc_pkg::UPCC_KIND_DATA: begin
                                    crc_bus.clr = RX_FIRST[p];
                                    shift_next = rx_byte;
                                    count_next = upcc_pkg::FIRST_BIT;
                                    ready_next[p] = 1'b0;
                                    state_next = upcc_pkg::UPCC_RX_SHIFT;
                                end
                                upcc_pkg::UPCC_KIND_CHECK: begin
                                    // The engine is stopped here; compare directly.
                                    if (rx_byte == crc_bus.rem) begin
                                        accept_next[p] = 1'b1;
                                    end else begin
                                        reject_next[p] = 1'b1;
                                    end
                                end
                                default: begin
                                    // Alive-counter bytes pass without touching the remainder.
                                    state_next = state_reg;
                                end
                            endcase
                        end
                    end
                    upcc_pkg::UPCC_RX_SHIFT: begin
                        crc_bus.shift = 1'b1;
                        shift_next = {1'b0, shift_reg[upcc_pkg::CRC_W-1:1]};
                        count_next = count_reg + 1'b1;
                        if (count_reg == upcc_pkg::LAST_BIT) begin
                            ready_next[p] = 1'b1;
                            state_next = upcc_pkg::UPCC_RX_IDLE;
                        end
                    end
                    default: begin
                        state_next = upcc_pkg::UPCC_RX_IDLE;
                    end
                endcase
            end

            always_ff @(posedge SYS_CLK or posedge RESET) begin
                if (RESET) begin
                    state_reg <= upcc_pkg::UPCC_RX_IDLE;
                    shift_reg <= upcc_pkg::CLEAR_VALUE;
                    count_reg <= upcc_pkg::FIRST_BIT;
                end else begin
                    state_reg <= state_next;
                    shift_reg <= shift_next;
                    count_reg <= count_next;
                end
            end
        end
    endgenerate

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            ready_reg <= '1;
            accept_reg <= '0;
            reject_reg <= '0;
        end else begin
            ready_reg <= ready_next;
            accept_reg <= accept_next;
            reject_reg <= reject_next;
        end
    end

    assign RX_READY = ready_reg;
    assign CMD_ACCEPT = accept_reg;
    assign CMD_REJECT = reject_reg;

    // ****************************************************************
    // Error flags
    // ****************************************************************
    logic set_up;
    logic set_down;
    logic [upcc_pkg::NUM_PATHS-1:0] path_flags;

    // Without a second UART every reception counts as the up path.
    assign set_up = reject_reg[upcc_pkg::UP_PATH]
        | (reject_reg[upcc_pkg::DOWN_PATH] & ~DUAL_UART);
    assign set_down = reject_reg[upcc_pkg::DOWN_PATH] & DUAL_UART;

    upcc_err_flags u_flags (
        .clk(SYS_CLK),
        .rst(RESET),
        .set_up(set_up),
        .set_down(set_down),
        .clear(FLAG_CLEAR),
        .second_alert_status_reg(path_flags),
        .first_alert_status_reg(SUMMARY_CHECK_ERROR_FLAG)
    );

    assign UP_PATH_CHECK_ERROR_FLAG = path_flags[upcc_pkg::UP_PATH];
    assign DOWN_PATH_CHECK_ERROR_FLAG = path_flags[upcc_pkg::DOWN_PATH];

    // ****************************************************************
    // Transmit path
    // ****************************************************************
    upcc_pkg::upcc_tx_state_e tx_state_reg;
    upcc_pkg::upcc_tx_state_e tx_state_next;
    logic [upcc_pkg::CRC_W-1:0] tx_shift_reg;
    logic [upcc_pkg::CRC_W-1:0] tx_shift_next;
    logic [upcc_pkg::CRC_W-1:0] tx_hold_reg;
    logic [upcc_pkg::CRC_W-1:0] tx_hold_next;
    logic [upcc_pkg::BIT_CNT_W-1:0] tx_count_reg;
    logic [upcc_pkg::BIT_CNT_W-1:0] tx_count_next;
    logic tx_last_reg;
    logic tx_last_next;
    logic tx_ready_reg;
    logic tx_ready_next;
    logic out_valid_reg;
    logic out_valid_next;
    logic [upcc_pkg::CRC_W-1:0] out_byte_reg;
    logic [upcc_pkg::CRC_W-1:0] out_byte_next;
    logic out_check_reg;
    logic out_check_next;

    upcc_crc_if tx_bus (
        .clk(SYS_CLK),
        .rst(RESET)
    );

    upcc_crc_engine u_tx_engine (
        .bus(tx_bus.eng)
    );

    always_comb begin
        tx_state_next = tx_state_reg;
        tx_shift_next = tx_shift_reg;
        tx_hold_next = tx_hold_reg;
        tx_count_next = tx_count_reg;
        tx_last_next = tx_last_reg;
        tx_ready_next = tx_ready_reg;
        out_valid_next = out_valid_reg;
        out_byte_next = out_byte_reg;
        out_check_next = out_check_reg;
        tx_bus.clr = 1'b0;
        tx_bus.shift = 1'b0;
        tx_bus.din = tx_shift_reg[0];
        case (tx_state_reg)
            upcc_pkg::UPCC_TX_IDLE: begin
                if (TX_VALID && tx_ready_reg) begin
                    tx_bus.clr = TX_FIRST;
                    tx_shift_next = TX_BYTE;
                    tx_hold_next = TX_BYTE;
                    tx_last_next = TX_LAST;
                    tx_count_next = upcc_pkg::FIRST_BIT;
                    tx_ready_next = 1'b0;
                    tx_state_next = upcc_pkg::UPCC_TX_SHIFT;
                end
            end
            upcc_pkg::UPCC_TX_SHIFT: begin
                tx_bus.shift = 1'b1;
                tx_shift_next = {1'b0, tx_shift_reg[upcc_pkg::CRC_W-1:1]};
                tx_count_next = tx_count_reg + 1'b1;
                if (tx_count_reg == upcc_pkg::LAST_BIT) begin
                    out_valid_next = 1'b1;
                    out_byte_next = tx_hold_reg;
                    tx_state_next = upcc_pkg::UPCC_TX_EMIT_DATA;
                end
            end
            upcc_pkg::UPCC_TX_EMIT_DATA: begin
                if (OUT_READY) begin
                    if (tx_last_reg) begin
                        // The check byte follows the last data byte directly.
                        out_byte_next = tx_bus.rem;
                        out_check_next = 1'b1;
                        tx_state_next = upcc_pkg::UPCC_TX_EMIT_CHECK;
                    end else begin
                        out_valid_next = 1'b0;
                        tx_ready_next = 1'b1;
                        tx_state_next = upcc_pkg::UPCC_TX_IDLE;
                    end
                end
            end
            upcc_pkg::UPCC_TX_EMIT_CHECK: begin
                if (OUT_READY) begin
                    out_valid_next = 1'b0;
                    out_check_next = 1'b0;
                    tx_ready_next = 1'b1;
                    tx_state_next = upcc_pkg::UPCC_TX_IDLE;
                end
            end
            default: begin
                tx_state_next = upcc_pkg::UPCC_TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            tx_state_reg <= upcc_pkg::UPCC_TX_IDLE;
            tx_shift_reg <= upcc_pkg::CLEAR_VALUE;
            tx_hold_reg <= upcc_pkg::CLEAR_VALUE;
            tx_count_reg <= upcc_pkg::FIRST_BIT;
            tx_last_reg <= 1'b0;
            tx_ready_reg <= 1'b1;
            out_valid_reg <= 1'b0;
            out_byte_reg <= upcc_pkg::CLEAR_VALUE;
            out_check_reg <= 1'b0;
        end else begin
            tx_state_reg <= tx_state_next;
            tx_shift_reg <= tx_shift_next;
            tx_hold_reg <= tx_hold_next;
            tx_count_reg <= tx_count_next;
            tx_last_reg <= tx_last_next;
            tx_ready_reg <= tx_ready_next;
            out_valid_reg <= out_valid_next;
            out_byte_reg <= out_byte_next;
            out_check_reg <= out_check_next;
        end
    end

    assign TX_READY = tx_ready_reg;
    assign OUT_VALID = out_valid_reg;
    assign OUT_BYTE = out_byte_reg;
    assign OUT_IS_CHECK = out_check_reg;
endmodule : upcc_packet_checker

`default_nettype wire

// *** upcc_packet_checker_bench.sv ***
// Self-checking testbench for the packet check byte block.
`timescale 1ns/1ns
`default_nettype none

module upcc_packet_checker_bench;
    logic sys_clk, reset, dual, tx_valid, tx_first, tx_last, tx_ready, slow, host_done;
    logic out_valid, out_is_check, out_ready, up_flag, dn_flag, sum_flag;
    logic exp_up, exp_dn, exp_sum;
    logic [1:0] rx_valid, rx_first, rx_ready, acc, rej;
    logic [15:0] rx_byte, lfsr;
    logic [3:0] rx_kind;
    logic [2:0] flag_clear;
    logic [7:0] tx_byte, out_byte, host_rem, host_data_rem, host_check;
    int fail_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    upcc_packet_checker u_upcc_packet_checker (.SYS_CLK(sys_clk), .RESET(reset),
        .DUAL_UART(dual), .RX_VALID(rx_valid), .RX_FIRST(rx_first), .RX_BYTE(rx_byte),
        .RX_KIND(rx_kind), .RX_READY(rx_ready), .CMD_ACCEPT(acc), .CMD_REJECT(rej),
        .FLAG_CLEAR(flag_clear), .UP_PATH_CHECK_ERROR_FLAG(up_flag),
        .DOWN_PATH_CHECK_ERROR_FLAG(dn_flag), .SUMMARY_CHECK_ERROR_FLAG(sum_flag),
        .TX_VALID(tx_valid), .TX_FIRST(tx_first), .TX_LAST(tx_last), .TX_BYTE(tx_byte),
        .TX_READY(tx_ready), .OUT_VALID(out_valid), .OUT_BYTE(out_byte),
        .OUT_IS_CHECK(out_is_check), .OUT_READY(out_ready));
    upcc_host_model u_upcc_host_model (.clk(sys_clk), .rst(reset), .slow(slow),
        .out_valid(out_valid), .out_is_check(out_is_check), .out_byte(out_byte),
        .out_ready(out_ready), .done(host_done), .rem(host_rem), .data_rem(host_data_rem),
        .check(host_check));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    function automatic logic [7:0] crc8(input logic [7:0] r, input logic [7:0] b);
        r = r ^ b;
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ 8'hB2) : (r >> 1);
        end
        return r;
    endfunction : crc8

    function automatic logic [7:0] rnd();
        repeat (8) lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction : rnd

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    // Holds a byte on one receive path until the block has taken it.
    task automatic rx_put(input int p, input upcc_pkg::upcc_kind_e k, input logic f,
                          input logic [7:0] b);
        @(posedge sys_clk);
        rx_valid[p] <= 1'b1;
        rx_first[p] <= f;
        rx_kind[2*p +: 2] <= k;
        rx_byte[8*p +: 8] <= b;
        @(negedge sys_clk);
        while (rx_ready[p] !== 1'b1) @(negedge sys_clk);
        @(posedge sys_clk);
        rx_valid[p] <= 1'b0;
        rx_byte[8*p +: 8] <= ~b;
    endtask : rx_put

    task automatic rx_pkt(input int p, input int n, input logic bad, input logic alive);
        logic [7:0] c;
        logic [7:0] b;
        c = 8'h00;
        for (int i = 0; i < n; i++) begin
            b = rnd();
            c = crc8(c, b);
            rx_put(p, upcc_pkg::UPCC_KIND_DATA, i == 0, b);
        end
        if (alive) rx_put(p, upcc_pkg::UPCC_KIND_ALIVE, 1'b1, rnd());
        if (bad) c = c ^ (8'h01 << (rnd() & 8'h07));
        rx_put(p, upcc_pkg::UPCC_KIND_CHECK, 1'b0, c);
        @(negedge sys_clk);
        check(acc[p], !bad, "accept");
        check(rej[p], bad, "reject");
        if (bad) begin
            exp_sum = 1'b1;
            if (dual && p == 1) exp_dn = 1'b1;
            else exp_up = 1'b1;
        end
        @(negedge sys_clk);
        check({up_flag, dn_flag, sum_flag}, {exp_up, exp_dn, exp_sum}, "flags");
    endtask : rx_pkt

    task automatic clear_some();
        logic [7:0] m;
        m = rnd();
        @(posedge sys_clk);
        flag_clear <= m[2:0];
        @(posedge sys_clk);
        flag_clear <= 3'h0;
        exp_up = exp_up & ~m[0];
        exp_dn = exp_dn & ~m[1];
        exp_sum = exp_sum & ~m[2];
        @(negedge sys_clk);
        check({up_flag, dn_flag, sum_flag}, {exp_up, exp_dn, exp_sum}, "cleared");
    endtask : clear_some

    task automatic tx_pkt(input int n);
        logic [7:0] c;
        logic [7:0] b;
        c = 8'h00;
        for (int i = 0; i < n; i++) begin
            b = rnd();
            c = crc8(c, b);
            @(posedge sys_clk);
            tx_valid <= 1'b1;
            tx_first <= i == 0;
            tx_last <= i == n - 1;
            tx_byte <= b;
            @(negedge sys_clk);
            while (tx_ready !== 1'b1) @(negedge sys_clk);
            @(posedge sys_clk);
            tx_valid <= 1'b0;
            tx_byte <= ~b;
        end
        @(negedge sys_clk);
        while (tx_ready !== 1'b1) @(negedge sys_clk);
        check(host_done, 1'b1, "tx done");
        check(host_data_rem, c, "tx data");
        check(host_check, c, "tx check");
        check(host_rem, 8'h00, "tx zero remainder");
    endtask : tx_pkt

    // A hang is cut short after far more cycles than the whole run needs.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            stop_test();
        end
    end

    initial begin
        reset = 1'b1;
        dual = 1'b0;
        rx_valid = 2'h0;
        rx_first = 2'h0;
        rx_byte = 16'h0000;
        rx_kind = 4'h0;
        flag_clear = 3'h0;
        tx_valid = 1'b0;
        tx_first = 1'b0;
        tx_last = 1'b0;
        tx_byte = 8'h00;
        slow = 1'b0;
        lfsr = 16'h5A80;
        exp_up = 1'b0;
        exp_dn = 1'b0;
        exp_sum = 1'b0;
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        for (int k = 0; k < 32; k++) begin
            @(posedge sys_clk);
            dual <= k[2];
            rx_pkt(k % 2, 1 + (rnd() & 8'h07), k < 8 || (rnd() & 8'h03) == 8'h00, k[0] ^ k[3]);
            if (k % 5 == 4) clear_some();
        end
        $display("receive tests done");
        for (int j = 0; j < 12; j++) begin
            @(posedge sys_clk);
            slow <= j[0];
            tx_pkt(1 + (rnd() & 8'h07));
        end
        tx_pkt(25);
        $display("transmit tests done");
        stop_test();
    end
endmodule : upcc_packet_checker_bench

`default_nettype wire

// *** upcc_packet_checker_monitor.sv ***
// Concurrent assertions on the ports of the packet check byte block.
`timescale 1ns/1ns
`default_nettype none

module upcc_packet_checker_monitor (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic DUAL_UART,
    input wire logic [upcc_pkg::NUM_PATHS-1:0] RX_VALID,
    input wire logic [upcc_pkg::NUM_PATHS*upcc_pkg::KIND_W-1:0] RX_KIND,
    input wire logic [upcc_pkg::NUM_PATHS-1:0] RX_READY,
    input wire logic [upcc_pkg::NUM_PATHS-1:0] CMD_ACCEPT,
    input wire logic [upcc_pkg::NUM_PATHS-1:0] CMD_REJECT,
    input wire logic [upcc_pkg::CLR_W-1:0] FLAG_CLEAR,
    input wire logic UP_PATH_CHECK_ERROR_FLAG,
    input wire logic DOWN_PATH_CHECK_ERROR_FLAG,
    input wire logic SUMMARY_CHECK_ERROR_FLAG,
    input wire logic TX_VALID,
    input wire logic TX_READY,
    input wire logic OUT_VALID,
    input wire logic [upcc_pkg::CRC_W-1:0] OUT_BYTE,
    input wire logic OUT_IS_CHECK,
    input wire logic OUT_READY
);
    default clocking mon_clk @(posedge SYS_CLK);
    endclocking
    default disable iff (RESET);

    sequence rx_data_take;
        RX_VALID[0] && RX_READY[0] && RX_KIND[1:0] == upcc_pkg::UPCC_KIND_DATA;
    endsequence
    sequence rx_check_take;
        RX_VALID[0] && RX_READY[0] && RX_KIND[1:0] == upcc_pkg::UPCC_KIND_CHECK;
    endsequence
    sequence tx_take;
        TX_VALID && TX_READY;
    endsequence

    shift_gap_a: assert property (rx_data_take |=> !RX_READY[0] [*8] ##1 RX_READY[0])
        else $error("receive ready gap is not eight cycles");
    verdict_once_a: assert property (rx_check_take |=> (CMD_ACCEPT[0] ^ CMD_REJECT[0]) ##1
        !(CMD_ACCEPT[0] || CMD_REJECT[0])) else $error("check verdict is not a single pulse");
    verdict_cause_a: assert property (CMD_ACCEPT[1] || CMD_REJECT[1] |->
        $past(RX_VALID[1] && RX_READY[1] && RX_KIND[3:2] == upcc_pkg::UPCC_KIND_CHECK))
        else $error("verdict without a check byte");
    summary_set_a: assert property (|CMD_REJECT |=> SUMMARY_CHECK_ERROR_FLAG)
        else $error("summary flag not set on reject");
    up_map_a: assert property (CMD_REJECT[0] || !DUAL_UART && CMD_REJECT[1] |=>
        UP_PATH_CHECK_ERROR_FLAG) else $error("up path flag not set");
    down_map_a: assert property (DUAL_UART && CMD_REJECT[1] |=> DOWN_PATH_CHECK_ERROR_FLAG)
        else $error("down path flag not set");
    down_cause_a: assert property ($rose(DOWN_PATH_CHECK_ERROR_FLAG) |->
        $past(DUAL_UART && CMD_REJECT[1])) else $error("down path flag set without cause");
    summary_cause_a: assert property ($rose(SUMMARY_CHECK_ERROR_FLAG) |-> $past(|CMD_REJECT))
        else $error("summary flag set without reject");
    summary_hold_a: assert property (SUMMARY_CHECK_ERROR_FLAG && !FLAG_CLEAR[2] |=>
        SUMMARY_CHECK_ERROR_FLAG) else $error("summary flag dropped without clear");
    tx_delay_a: assert property (tx_take |=> !OUT_VALID [*8] ##1 OUT_VALID)
        else $error("output byte not after eight shift cycles");
    check_after_a: assert property ($rose(OUT_IS_CHECK) |-> $past(OUT_VALID && OUT_READY))
        else $error("check byte before data handshake");
    out_hold_a: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_BYTE)
        && $stable(OUT_IS_CHECK)) else $error("output byte changed while stalled");
endmodule : upcc_packet_checker_monitor

bind upcc_packet_checker upcc_packet_checker_monitor u_upcc_packet_checker_monitor (
    .SYS_CLK, .RESET, .DUAL_UART, .RX_VALID, .RX_KIND, .RX_READY, .CMD_ACCEPT, .CMD_REJECT,
    .FLAG_CLEAR, .UP_PATH_CHECK_ERROR_FLAG, .DOWN_PATH_CHECK_ERROR_FLAG,
    .SUMMARY_CHECK_ERROR_FLAG, .TX_VALID, .TX_READY, .OUT_VALID, .OUT_BYTE, .OUT_IS_CHECK,
    .OUT_READY
);

`default_nettype wire

// *** upcc_pkg.sv ***
// Constants and types shared by the packet check byte logic.
// How it works
// - A bad check byte sets the path error flag and the summary flag.
// - Single-UART setups report every check failure on the up-path flag.
// - Dual-UART setups flag up-path and down-path failures separately.
// - A command is accepted only when its check byte equals the remainder.
// - Both ends use CRC-8 with polynomial x^8+x^6+x^3+x^2+1 (0xA6).
// - The engine consumes the stream least significant bit first.
// - Remainder bits seven to zero are check byte bits seven to zero.
// - Per packet: clear engine, feed stream, stop, compare following check byte.
// - On mismatch the transaction is dropped and the summary flag raised.
// - Outgoing data runs through a cleared engine; remainder is sent after it.
// - Only data bytes before the check byte count; alive-counter and other non-data bytes do not.
`default_nettype none

package upcc_pkg;
    localparam int CRC_W = 8;
    localparam int BIT_CNT_W = 3;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;
    localparam logic [BIT_CNT_W-1:0] FIRST_BIT = 3'h0;
    localparam logic [CRC_W-1:0] GENERATOR_REFLECTED_GENERATOR_CONST = 8'hA6;
    localparam logic [CRC_W-1:0] REFLECTED_GENERATOR_CONST = 8'hB2;
    localparam logic [CRC_W-1:0] CLEAR_VALUE = 8'h00;
    localparam int NUM_PATHS = 2;
    localparam int UP_PATH = 0;
    localparam int DOWN_PATH = 1;
    localparam int KIND_W = 2;
    localparam int CLR_UP = 0;
    localparam int CLR_DOWN = 1;
    localparam int CLR_SUMMARY = 2;
    localparam int CLR_W = 3;

    typedef enum logic [KIND_W-1:0] {
        UPCC_KIND_DATA,
        UPCC_KIND_ALIVE,
        UPCC_KIND_CHECK,
        UPCC_KIND_NONE
    } upcc_kind_e;

    typedef enum logic [0:0] {
        UPCC_RX_IDLE,
        UPCC_RX_SHIFT
    } upcc_rx_state_e;

    typedef enum logic [1:0] {
        UPCC_TX_IDLE,
        UPCC_TX_SHIFT,
        UPCC_TX_EMIT_DATA,
        UPCC_TX_EMIT_CHECK
    } upcc_tx_state_e;
endpackage : upcc_pkg

`default_nettype wire
